// file: pkg/sbcf_pkg.sv
// Purpose: shared constants and types for the bus control flag block
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes:   offsets are byte addresses, one aligned word per register

package sbcf_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;       // bus_control_flags
  localparam logic [7:0] DATA_OFFSET = 8'h04;       // data_buffer_reg
  localparam logic [7:0] CFG_OFFSET  = 8'h08;       // role and address setup

  // bus_control_flags field positions
  localparam int unsigned CTRL_MASTER_BIT = 7;
  localparam int unsigned CTRL_TX_BIT     = 6;
  localparam int unsigned CTRL_STA_BIT    = 5;
  localparam int unsigned CTRL_STO_BIT    = 4;
  localparam int unsigned CTRL_ACKRQ_BIT  = 3;
  localparam int unsigned CTRL_ARB_BIT    = 2;
  localparam int unsigned CTRL_ACK_BIT    = 1;
  localparam int unsigned CTRL_SI_BIT     = 0;

  // configuration field positions
  localparam int unsigned CFG_MST_EN_BIT  = 0;
  localparam int unsigned CFG_HW_ACK_BIT  = 1;
  localparam int unsigned CFG_GC_BIT      = 2;
  localparam int unsigned CFG_ADDR_LSB    = 8;
  localparam int unsigned CFG_MASK_LSB    = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] MASK_RESET = 7'h7f;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned HALF_BIT_NS   = 5000;
  localparam int unsigned HALF_BIT_CYC  = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  HALF_LAST     = 8'(HALF_BIT_CYC - 1);
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic scl;    // synchronised clock line level
    logic sda;    // synchronised data line level
    logic rise;   // clock line rose
    logic fall;   // clock line fell
    logic start;  // start condition seen
    logic stop;   // stop condition seen
    logic busy;   // between start and stop
  } sbcf_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_START     = 3'b001,
    ST_HOLD      = 3'b010,
    ST_BYTE      = 3'b011,
    ST_RSTART    = 3'b100,
    ST_STOP_LOW  = 3'b101,
    ST_STOP_HIGH = 3'b110
  } sbcf_state_t;

endpackage

// file: hdl/sbcf_bus_sync.sv
// Purpose: bring the bus lines into the clock domain and find conditions
// Assumes: lines idle high; inputs asynchronous to clk
// Notes:   all outputs registered, three cycles behind the pins

module sbcf_bus_sync (
  input  wire logic              clk,      // system clock
  input  wire logic              reset_n,  // synchronous reset
  input  wire logic              scl_in,   // clock line pin level
  input  wire logic              sda_in,   // data line pin level
  output sbcf_pkg::sbcf_bus_t    bus       // line levels and events
);

  logic scl_m;
  logic scl_q;
  logic sda_m;
  logic sda_q;

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_m <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_q <= scl_m;
      sda_m <= sda_in;
      sda_q <= sda_m;
    end
  end

  // edges and start/stop found against the previous sampled levels
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
    end else begin
      bus.scl   <= scl_q;
      bus.sda   <= sda_q;
      bus.rise  <= scl_q & ~bus.scl;
      bus.fall  <= ~scl_q & bus.scl;
      bus.start <= scl_q & bus.scl & bus.sda & ~sda_q;
      bus.stop  <= scl_q & bus.scl & ~bus.sda & sda_q;
      if (scl_q & bus.scl & bus.sda & ~sda_q) begin
        bus.busy <= 1'b1;
      end else if (scl_q & bus.scl & ~bus.sda & sda_q) begin
        bus.busy <= 1'b0;
      end
    end
  end

endmodule

// file: hdl/sbcf_flags.sv
// Purpose: control and status flags of one two-wire bus port, with its byte engine
// Assumes: APB slave, 20 MHz clk, open-drain lines driven low when oe is high
// Notes:   the port stalls the bus by holding the clock line while irq is pending
//
// The address map and the APB interface to the registers are this design's own decisions.

module sbcf_flags (
  input  wire logic        clk,      // system clock, 20 MHz
  input  wire logic        reset_n,  // synchronous reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error, unmapped address
  input  wire logic        scl_in,   // clock line level
  output logic             scl_out,  // clock line drive value
  output logic             scl_oe,   // clock line pulled low
  input  wire logic        sda_in,   // data line level
  output logic             sda_out,  // data line drive value
  output logic             sda_oe    // data line pulled low
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  sbcf_pkg::sbcf_bus_t   bus;
  sbcf_pkg::sbcf_state_t state;
  logic       master_f, tx_f, sta_f, sto_f, ackrq_f, arb_f, ack_f, si_f;
  logic       mst_en, hw_ack, gc_en;
  logic [6:0] own_addr, addr_mask;
  logic [7:0] data_buf, shift, ctrl_rd;
  logic [7:0] tcnt;
  logic [3:0] cnt;
  logic       ph, mscl, msda, addr_phase, addressed, ignore, wrote_pre, rx_bit;
  logic       ev_si, ev_sta, ev_sto, ev_stop_gen, ev_arb, ev_ackrq, ev_ack_done;
  logic       ev_ack_rx, ack_val, ev_rx;
  logic       apb_wr, wr_ctrl, wr_data, wr_cfg, byte_drv, match, half;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == sbcf_pkg::CTRL_OFFSET) | (a == sbcf_pkg::DATA_OFFSET) |
              (a == sbcf_pkg::CFG_OFFSET);
  endfunction

  sbcf_bus_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .bus     (bus)
  );

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // one wait state: pready rises the cycle after the access phase starts
  assign apb_wr  = psel & penable & pready & pwrite & reg_hit(paddr);
  assign wr_ctrl = apb_wr & (paddr == sbcf_pkg::CTRL_OFFSET);
  assign wr_data = apb_wr & (paddr == sbcf_pkg::DATA_OFFSET);
  assign wr_cfg  = apb_wr & (paddr == sbcf_pkg::CFG_OFFSET);

  // flag byte in its documented bit order
  always_comb begin
    ctrl_rd = sbcf_pkg::CTRL_RESET;
    ctrl_rd[sbcf_pkg::CTRL_MASTER_BIT] = master_f;
    ctrl_rd[sbcf_pkg::CTRL_TX_BIT]     = tx_f;
    ctrl_rd[sbcf_pkg::CTRL_STA_BIT]    = sta_f;
    ctrl_rd[sbcf_pkg::CTRL_STO_BIT]    = sto_f;
    ctrl_rd[sbcf_pkg::CTRL_ACKRQ_BIT]  = ackrq_f;
    ctrl_rd[sbcf_pkg::CTRL_ARB_BIT]    = arb_f;
    ctrl_rd[sbcf_pkg::CTRL_ACK_BIT]    = ack_f;
    ctrl_rd[sbcf_pkg::CTRL_SI_BIT]     = si_f;
  end

  // ready, error and read data all registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~reg_hit(paddr);
      prdata  <= 32'h0000_0000;
      if (psel & penable & ~pready & ~pwrite) begin
        unique case (paddr)
          sbcf_pkg::CTRL_OFFSET: prdata <= {24'h00_0000, ctrl_rd};
          sbcf_pkg::DATA_OFFSET: prdata <= {24'h00_0000, data_buf};
          sbcf_pkg::CFG_OFFSET:  prdata <= {9'h000, addr_mask, 1'b0, own_addr,
                                            5'h00, gc_en, hw_ack, mst_en};
          default:               prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mst_en    <= 1'b0;
      hw_ack    <= 1'b0;
      gc_en     <= 1'b0;
      own_addr  <= sbcf_pkg::ADDR_RESET;
      addr_mask <= sbcf_pkg::MASK_RESET;
    end else if (wr_cfg) begin
      mst_en    <= pwdata[sbcf_pkg::CFG_MST_EN_BIT];
      hw_ack    <= pwdata[sbcf_pkg::CFG_HW_ACK_BIT];
      gc_en     <= pwdata[sbcf_pkg::CFG_GC_BIT];
      own_addr  <= pwdata[sbcf_pkg::CFG_ADDR_LSB +: 7];
      addr_mask <= pwdata[sbcf_pkg::CFG_MASK_LSB +: 7];
    end
  end

  // data buffer: a received byte wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_buf  <= sbcf_pkg::DATA_RESET;
      wrote_pre <= 1'b0;
    end else begin
      if (ev_rx) begin
        data_buf <= shift;
      end else if (wr_data) begin
        data_buf <= pwdata[7:0];
      end
      if (bus.start) begin
        wrote_pre <= 1'b0;
      end else if (wr_data & ~bus.busy) begin
        wrote_pre <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // software-visible flags; hardware set always beats software clear
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      si_f <= 1'b0;
    end else if (ev_si) begin
      si_f <= 1'b1;
    end else if (wr_ctrl) begin
      si_f <= pwdata[sbcf_pkg::CTRL_SI_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arb_f <= 1'b0;
    end else if (ev_arb) begin
      arb_f <= 1'b1;
    end else if (wr_ctrl & si_f & ~pwdata[sbcf_pkg::CTRL_SI_BIT]) begin
      arb_f <= 1'b0;
    end
  end

  // a 1 only lands when master-enabled; a 0 always clears
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sta_f <= 1'b0;
      sto_f <= 1'b0;
    end else begin
      if (ev_sta) begin
        sta_f <= 1'b1;
      end else if (wr_ctrl & (mst_en | ~pwdata[sbcf_pkg::CTRL_STA_BIT])) begin
        sta_f <= pwdata[sbcf_pkg::CTRL_STA_BIT];
      end
      if (ev_sto) begin
        sto_f <= 1'b1;
      end else if (ev_stop_gen) begin
        sto_f <= 1'b0;
      end else if (wr_ctrl & (mst_en | ~pwdata[sbcf_pkg::CTRL_STO_BIT])) begin
        sto_f <= pwdata[sbcf_pkg::CTRL_STO_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_f   <= 1'b0;
      ackrq_f <= 1'b0;
    end else begin
      if (ev_ack_rx) begin
        ack_f <= ack_val;
      end else if (wr_ctrl) begin
        ack_f <= pwdata[sbcf_pkg::CTRL_ACK_BIT];
      end
      if (ev_ackrq) begin
        ackrq_f <= 1'b1;
      end else if (ev_ack_done) begin
        ackrq_f <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // byte engine
  // ****************************************************************
  assign half  = (tcnt == sbcf_pkg::HALF_LAST);
  // looked at on the eighth fall, before the last sampled bit is shifted in
  assign match = ((((shift[6:0] ^ own_addr) & addr_mask) == 7'h00) |
                 (gc_en & ({shift[6:0], rx_bit} == 8'h00)));

  always_ff @(posedge clk) begin : engine
    logic lose;
    lose = 1'b0;
    if (!reset_n) begin
      state <= sbcf_pkg::ST_IDLE;
      {master_f, tx_f, mscl, msda, ph, addr_phase, addressed, ignore} <= 8'h00;
      {ev_si, ev_sta, ev_sto, ev_stop_gen, ev_arb, ev_ackrq, ev_ack_done} <= 7'h00;
      {ev_ack_rx, ack_val, ev_rx} <= 3'h0;
      tcnt  <= 8'h00;
      cnt   <= 4'h0;
      shift <= 8'h00;
      rx_bit <= 1'b1;
    end else begin
      {ev_si, ev_sta, ev_sto, ev_stop_gen, ev_arb, ev_ackrq, ev_ack_done} <= 7'h00;
      {ev_ack_rx, ev_rx} <= 2'h0;
      unique case (state)
        sbcf_pkg::ST_IDLE: begin
          if (mst_en & sta_f & ~si_f & ~bus.busy) begin
            state <= sbcf_pkg::ST_START;
            msda  <= 1'b1;
            tcnt  <= 8'h00;
          end
        end
        sbcf_pkg::ST_START: begin
          msda <= 1'b1;
          tcnt <= tcnt + 8'h01;
          if (half) begin
            mscl     <= 1'b1;
            master_f <= 1'b1;
            tx_f     <= 1'b1;
            ev_si    <= 1'b1;
            state    <= sbcf_pkg::ST_HOLD;
          end
        end
        // ev_si still high means the flag lands next cycle: wait for it
        sbcf_pkg::ST_HOLD: begin
          tcnt <= 8'h00;
          ph   <= 1'b0;
          if (~si_f & ~ev_si) begin
            if (master_f & sta_f) begin
              state <= sbcf_pkg::ST_RSTART;
            end else if (master_f & sto_f) begin
              state <= sbcf_pkg::ST_STOP_LOW;
              msda  <= 1'b1;
            end else begin
              state <= sbcf_pkg::ST_BYTE;
              msda  <= 1'b0;
              if (cnt == 4'h0) begin
                shift <= data_buf;
              end
            end
          end
        end
        // release data with clock low, then release clock and check it
        sbcf_pkg::ST_RSTART: begin
          msda <= 1'b0;
          tcnt <= half ? 8'h00 : tcnt + 8'h01;
          if (half & ~ph) begin
            mscl <= 1'b0;
            ph   <= 1'b1;
          end else if (half & ~bus.scl) begin
            lose = 1'b1;
          end else if (half) begin
            state <= sbcf_pkg::ST_START;
          end
        end
        sbcf_pkg::ST_STOP_LOW: begin
          msda <= 1'b1;
          tcnt <= half ? 8'h00 : tcnt + 8'h01;
          if (half) begin
            mscl  <= 1'b0;
            state <= sbcf_pkg::ST_STOP_HIGH;
          end
        end
        sbcf_pkg::ST_STOP_HIGH: begin
          tcnt <= tcnt + 8'h01;
          if (half & ~bus.scl) begin
            lose = 1'b1;
          end else if (half) begin
            msda        <= 1'b0;
            master_f    <= 1'b0;
            ev_stop_gen <= 1'b1;
            state       <= sbcf_pkg::ST_IDLE;
          end
        end
        sbcf_pkg::ST_BYTE: begin
          // master clock: high half counts only once the line is seen high
          if (master_f & (mscl | bus.scl)) begin
            tcnt <= half ? 8'h00 : tcnt + 8'h01;
            if (half) begin
              mscl <= ~mscl;
            end
          end
          // sample at the rise, shift at the fall: driven data moves only while clock is low
          if (bus.rise & (cnt != sbcf_pkg::ACK_SLOT)) begin
            rx_bit <= bus.sda;
            if (master_f & tx_f & shift[7] & ~bus.sda) begin
              lose = 1'b1;
            end
          end else if (bus.rise & tx_f) begin
            ev_ack_rx <= 1'b1;
            ack_val   <= ~bus.sda;
          end
          if (bus.fall & (cnt == sbcf_pkg::LAST_DATA_BIT)) begin
            cnt   <= sbcf_pkg::ACK_SLOT;
            shift <= {shift[6:0], rx_bit};
            if (~tx_f | (~master_f & addr_phase)) begin
              ev_rx <= 1'b1;
              if (~master_f & addr_phase & hw_ack & ~match) begin
                ignore <= 1'b1;
                state  <= sbcf_pkg::ST_IDLE;
              end else begin
                ev_sta <= ~master_f & addr_phase;
                if (~hw_ack) begin
                  ev_ackrq <= 1'b1;
                  ev_si    <= 1'b1;
                  state    <= sbcf_pkg::ST_HOLD;
                end
              end
            end
          end else if (bus.fall & (cnt == sbcf_pkg::ACK_SLOT)) begin
            cnt         <= 4'h0;
            shift       <= data_buf;
            ev_ack_done <= 1'b1;
            if (addr_phase) begin
              addr_phase <= 1'b0;
              tx_f       <= master_f ? ~shift[0] : shift[0];
              addressed  <= ~master_f;
            end
            if (master_f & sto_f) begin
              state <= sbcf_pkg::ST_STOP_LOW;
              msda  <= 1'b1;
              tcnt  <= 8'h00;
            end else if (tx_f | hw_ack) begin
              ev_si <= 1'b1;
              state <= sbcf_pkg::ST_HOLD;
            end
          end else if (bus.fall) begin
            cnt   <= cnt + 4'h1;
            shift <= {shift[6:0], rx_bit};
          end
        end
        default: state <= sbcf_pkg::ST_IDLE;
      endcase
      // conditions seen on the bus override the sequencing above
      if (bus.start) begin
        cnt        <= 4'h0;
        addr_phase <= 1'b1;
        ignore     <= 1'b0;
        if ((state == sbcf_pkg::ST_START) | (state == sbcf_pkg::ST_RSTART)) begin
          tx_f <= 1'b0;
        end else if (master_f & ~sta_f) begin
          lose = 1'b1;
        end else if (~master_f) begin
          tx_f  <= wrote_pre;
          state <= sbcf_pkg::ST_BYTE;
          cnt   <= 4'hf;                                    // start's own fall wraps to 0
        end
      end
      if (bus.stop) begin
        addressed  <= 1'b0;
        addr_phase <= 1'b0;
        if (master_f & (state != sbcf_pkg::ST_STOP_HIGH)) begin
          lose = 1'b1;
          ev_sto <= 1'b1;
        end else if (addressed) begin
          ev_sto <= 1'b1;
          ev_si  <= 1'b1;
        end
        if (~master_f) begin
          state <= sbcf_pkg::ST_IDLE;
        end
      end
      if (lose) begin
        ev_arb   <= 1'b1;
        ev_si    <= 1'b1;
        master_f <= 1'b0;
        tx_f     <= 1'b0;
        mscl     <= 1'b0;
        msda     <= 1'b0;
        state    <= sbcf_pkg::ST_IDLE;
      end
    end
  end

  // ****************************************************************
  // line drive
  // ****************************************************************
  // slave never drives data during the address byte; the ack slot sends the chosen value
  always_comb begin
    byte_drv = 1'b0;
    if ((state == sbcf_pkg::ST_BYTE) & (cnt != sbcf_pkg::ACK_SLOT)) begin
      byte_drv = tx_f & (master_f | ~addr_phase) & ~shift[7];
    end else if (((state == sbcf_pkg::ST_BYTE) | (state == sbcf_pkg::ST_HOLD)) &
                 (cnt == sbcf_pkg::ACK_SLOT) & ~tx_f) begin
      byte_drv = (hw_ack & addr_phase & ~master_f) | ack_f;
    end
  end

  // pending irq stretches the clock line for as long as it stays set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_oe  <= si_f | mscl;
      sda_oe  <= msda | byte_drv;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

endmodule

// file: verif/sbcf_flags_props.sv
// Purpose: port checks for the flag block
// Assumes: one wait state per apb access
// Notes:   bound to sbcf_flags below
module sbcf_flags_props (
  input wire logic        clk,      // clock
  input wire logic        reset_n,  // reset
  input wire logic        psel,     // select
  input wire logic        penable,  // access
  input wire logic        pwrite,   // write
  input wire logic [7:0]  paddr,    // address
  input wire logic [31:0] prdata,   // rdata
  input wire logic        pready,   // ready
  input wire logic        pslverr,  // error
  input wire logic        scl_out,  // clk value
  input wire logic        scl_oe,   // clk pull
  input wire logic        sda_out   // data value
);
  // ****
  // checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // flag register read in its answer cycle
  logic rd_fl;
  assign rd_fl = pready && !pwrite && paddr == 8'h00;
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_PULSE: assert property (pready |-> !$past(pready)) else $error("ready held");
  AST_UNMAPPED: assert property (pready && paddr > 8'h08 |-> pslverr)
    else $error("unmapped not refused");
  AST_MAPPED: assert property (rd_fl |-> !pslverr && prdata[31:8] == 24'h00_0000)
    else $error("bad flag read");
  AST_IDLE: assert property (!pready |-> prdata == 32'h0000_0000) else $error("data leak");
  AST_STALL: assert property (rd_fl && prdata[0] |-> scl_oe) else $error("no stall");
  AST_ARB_ROLE: assert property (rd_fl && prdata[2] |-> !prdata[7])
    else $error("role kept");
  // open drain: the drive value must never be high
  AST_DRAIN: assert property (!scl_out && !sda_out) else $error("line driven high");
endmodule
bind sbcf_flags sbcf_flags_props u_props (.clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .scl_out, .scl_oe, .sda_out);

// file: verif/sbcf_peer.sv
// Purpose: far-end slave that acks every byte
// Assumes: open-drain lines with pull-ups
// Notes:   pulls data low in the ninth slot only
module sbcf_peer (
  input  wire logic scl,  // clock line
  input  wire logic sda,  // data line
  output logic      pull  // 1 = data low
);
  // ****
  // ack slot
  // ****
  int n = 0;
  initial pull = 1'b0;
  // a start restarts the count
  always @(negedge sda) if (scl) n = 0;
  // released at the next fall, so the master sees the line free again
  always @(negedge scl) begin
    n = n + 1;
    pull = n > 1 && n % 9 == 0;
  end
endmodule

// file: verif/tb.sv
// Purpose: self-checking bench for the flag block
// Assumes: peer acks every byte
// Notes:   bench plays a remote master, 400 ns bit
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, er, scl_oe, sda_oe, pull, dscl = 1, dsda = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  int          error_cnt = 0, n_checks = 0;
  // ****
  // wiring, pull-ups on both lines
  // ****
  wire scl = ~(scl_oe | ~dscl), sda = ~(sda_oe | ~dsda | pull);
  sbcf_flags u_sbcf_flags (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda),
    .sda_out(), .sda_oe);
  sbcf_peer u_sbcf_peer (.scl, .sda, .pull);
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 0);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll flags until bit b reads v
  task automatic wbit(input int b, input logic v);
    apb(1'b0, 8'h00);
    for (int i = 0; i < 3000 && rd[b] !== v; i++) apb(1'b0, 8'h00);
  endtask
  // one remote bit, data moves only while the clock is low
  task automatic lbit(input logic v);
    repeat (2) @(posedge clk);
    dsda <= v;
    repeat (2) @(posedge clk);
    dscl <= 1'b1;
    repeat (4) @(posedge clk);
    dscl <= 1'b0;
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h00);
    chk("flags", rd, 32'h0000_0000);
    apb(1'b0, 8'h08);
    chk("cfg", rd, 32'h007f_0000);
    apb(1'b0, 8'h0c);
    chk("err", 32'(er), 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0031);
    apb(1'b0, 8'h00);
    chk("force", rd, 32'h0000_0001);
    apb(1'b1, 8'h00);
    apb(1'b0, 8'h00);
    chk("clear", rd, 32'h0000_0000);
  endtask
  task automatic t_master;
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_00a4);
    apb(1'b1, 8'h00, 32'h0000_0020);
    wbit(0, 1'b1);
    chk("start", rd & 32'h0000_00c1, 32'h0000_00c1);
    apb(1'b1, 8'h00);
    wbit(0, 1'b1);
    chk("ack", rd & 32'h0000_00c7, 32'h0000_00c3);
    apb(1'b1, 8'h00, 32'h0000_0010);
    wbit(7, 1'b0);
    chk("stop", rd & 32'h0000_0011, 32'h0000_0000);
  endtask
  task automatic t_slave;
    apb(1'b1, 8'h08);
    repeat (200) @(posedge clk);
    dsda <= 1'b0;
    repeat (4) @(posedge clk);
    dscl <= 1'b0;
    for (int i = 7; i >= 0; i--) lbit(i == 5);
    wbit(0, 1'b1);
    chk("addr", rd & 32'h0000_00bd, 32'h0000_0029);
    chk("hold", 32'(scl_oe), 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk("ack out", 32'(sda_oe), 32'h0000_0001);
    lbit(1'b1);
    repeat (8) @(posedge clk);
    apb(1'b0, 8'h00);
    chk("ack done", rd & 32'h0000_0009, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_master;
    t_slave;
    wrap_up;
  end
  // watchdog, the run needs about 2600 cycles
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
endmodule
